// file: sbml_pkg.sv
// Purpose: Shared constants and types of the buffer manager limits bank
// Assumes: Registers sit at their printed register numbers on a plain port
// Notes:   Usage counts are in buffers of BUF_BYTES bytes each
`default_nettype none
package sbml_pkg;
   // ------------------------------------------------------------
   // Register numbers
   // ------------------------------------------------------------
   localparam int          ADDR_W   = 16;
   localparam logic [15:0] ADR_CFG  = 16'h1c00;
   localparam logic [15:0] ADR_DROP = 16'h1c01;
   localparam logic [15:0] ADR_PAUS = 16'h1c02;
   localparam logic [15:0] ADR_RESU = 16'h1c03;
   localparam logic [15:0] ADR_FLOD = 16'h1c04;
   localparam logic [15:0] ADR_CNT0 = 16'h1c05;
   localparam logic [15:0] ADR_CNT1 = 16'h1c06;
   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int         CFG_W        = 7;
   localparam int         LVL_W        = 16;
   localparam int         FLOOD_W      = 8;
   localparam logic [6:0] CFG_RST      = 7'h00;
   localparam logic [7:0] DROP_LOW_RST = 8'h49;
   localparam logic [7:0] DROP_HI_RST  = 8'h64;
   localparam logic [7:0] PAUS_LOW_RST = 8'h21;
   localparam logic [7:0] PAUS_HI_RST  = 8'h3c;
   localparam logic [7:0] RESU_LOW_RST = 8'h03;
   localparam logic [7:0] RESU_HI_RST  = 8'h07;
   localparam logic [7:0] FLOOD_RST    = 8'h31;
   localparam logic [31:0] CNT_RST     = 32'h0000_0000;
   localparam logic [31:0] CNT_TEST    = 32'h07ff_fffc;
   localparam logic [31:0] CNT_MAX     = 32'h0fff_ffff;
   // ------------------------------------------------------------
   // Buffer accounting
   // ------------------------------------------------------------
   localparam int         NPORT       = 3;
   localparam int         NCNT        = 2;
   localparam int         USE_W       = 10;
   localparam int         BUF_BYTES   = 128;
   localparam logic [9:0] ACTIVE_BUFS = 10'h024;
   // Configuration fields, bit 6 down to bit 0
   typedef struct packed {
      logic       cnt_test;
      logic       fix_prio;
      logic [2:0] pace_en;
      logic       yellow_en;
      logic       red_en;
   } sbml_cfg_type;
   // Threshold pair, low set in 15:8
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
   } sbml_lvl_type;
   // Admission request from ingress
   typedef struct packed {
      logic       valid;
      logic [1:0] port;
      logic       red;
      logic       flood;
   } sbml_adm_type;
endpackage : sbml_pkg
`default_nettype wire

// file: sbml_limits.sv
// Purpose: Buffer manager configuration, limit selection and drop counters
// Assumes: Engine inputs share clk; one admission request per cycle
// Notes:   Read data stand one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module sbml_limits (
   // Clock and reset
   input  wire logic                                   clk,
   input  wire logic                                   srst,
   // Register port
   input  wire logic [sbml_pkg::ADDR_W-1:0]            reg_addr,
   input  wire logic [31:0]                            reg_wdata,
   input  wire logic                                   reg_wr,
   input  wire logic                                   reg_rd,
   output logic      [31:0]                            reg_rdata,
   // Buffer usage from the engine
   input  wire logic [sbml_pkg::NPORT-1:0][sbml_pkg::USE_W-1:0] buf_used,
   input  wire logic [sbml_pkg::USE_W-1:0]             flood_used,
   input  wire logic [sbml_pkg::NPORT-1:0]             yellow_drop,
   // Admission request and answer
   input  wire sbml_pkg::sbml_adm_type                 adm_req,
   output logic                                        adm_done,
   output logic                                        adm_drop,
   // Settings to the engine
   output sbml_pkg::sbml_cfg_type                      cfg_out,
   output logic      [1:0]                             active_cnt,
   output logic      [sbml_pkg::NPORT-1:0]             over_limit,
   output logic      [sbml_pkg::NPORT-1:0]             pause_send,
   output logic      [sbml_pkg::NPORT-1:0]             resume_send
);
   import sbml_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   sbml_cfg_type       cfg_q,   cfg_d;
   sbml_lvl_type       drop_q,  drop_d;
   sbml_lvl_type       paus_q,  paus_d;
   sbml_lvl_type       resu_q,  resu_d;
   logic [7:0]         flood_q, flood_d;
   logic [31:0]        cnt_q [NCNT];
   logic [31:0]        cnt_d [NCNT];
   logic [31:0]        rdata_q, rdata_d;

   // ------------------------------------------------------------
   // Limit selection
   // ------------------------------------------------------------
   logic               low_set;
   logic [7:0]         drop_lim;
   logic [7:0]         paus_lim;
   logic [7:0]         resu_lim;
   logic [1:0]         act_n;

   always_comb begin
      act_n = 2'h0;
      for (int p = 0; p < NPORT; p++) begin
         if (buf_used[p] >= ACTIVE_BUFS) begin
            act_n = act_n + 2'h1;
         end
      end
   end

   assign low_set  = (act_n >= 2'h2);
   assign drop_lim = low_set ? drop_q.low : drop_q.high;
   assign paus_lim = low_set ? paus_q.low : paus_q.high;
   assign resu_lim = low_set ? resu_q.low : resu_q.high;

   // ------------------------------------------------------------
   // Over-limit flags and flow control
   // ------------------------------------------------------------
   logic [NPORT-1:0]   paused_q, paused_d;
   logic [NPORT-1:0]   psend_q,  psend_d;
   logic [NPORT-1:0]   rsend_q,  rsend_d;
   logic [NPORT-1:0]   over_q,   over_d;

   // Pause is a level of state so a port is paused once, not every cycle
   always_comb begin
      paused_d = paused_q;
      psend_d  = '0;
      rsend_d  = '0;
      for (int p = 0; p < NPORT; p++) begin
         over_d[p] = (buf_used[p] >= {2'h0, drop_lim});
         if (!paused_q[p] && buf_used[p] >= {2'h0, paus_lim}) begin
            paused_d[p] = 1'b1;
            psend_d[p]  = 1'b1;
         end else if (paused_q[p] && buf_used[p] <= {2'h0, resu_lim}) begin
            paused_d[p] = 1'b0;
            rsend_d[p]  = 1'b1;
         end
      end
   end

   // Flow control state
   always_ff @(posedge clk) begin
      if (srst) begin
         paused_q <= '0;
         psend_q  <= '0;
         rsend_q  <= '0;
         over_q   <= '0;
      end else begin
         paused_q <= paused_d;
         psend_q  <= psend_d;
         rsend_q  <= rsend_d;
         over_q   <= over_d;
      end
   end

   // ------------------------------------------------------------
   // Admission check
   // ------------------------------------------------------------
   logic               done_q, done_d;
   logic               drp_q,  drp_d;
   logic [1:0]         dport_q, dport_d;
   logic [NCNT-1:0]    inc;

   // Port code 3 is not a port; such a request is ignored
   always_comb begin
      done_d  = adm_req.valid && (adm_req.port < 2'h3);
      dport_d = adm_req.port;
      drp_d   = 1'b0;
      if (done_d) begin
         if (adm_req.red && cfg_q.red_en) begin
            drp_d = 1'b1;
         end
         if (buf_used[adm_req.port] >= {2'h0, drop_lim}) begin
            drp_d = 1'b1;
         end
         if (adm_req.flood && flood_used >= {2'h0, flood_q}) begin
            drp_d = 1'b1;
         end
      end
   end

   // Admission answer
   always_ff @(posedge clk) begin
      if (srst) begin
         done_q  <= 1'b0;
         drp_q   <= 1'b0;
         dport_q <= 2'h0;
      end else begin
         done_q  <= done_d;
         drp_q   <= drp_d;
         dport_q <= dport_d;
      end
   end

   always_comb begin
      for (int c = 0; c < NCNT; c++) begin
         inc[c] = (done_q && drp_q && dport_q == c[1:0]) || yellow_drop[c];
      end
   end

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   logic [NCNT-1:0]    cnt_rd;

   assign cnt_rd[0] = reg_rd && (reg_addr == ADR_CNT0);
   assign cnt_rd[1] = reg_rd && (reg_addr == ADR_CNT1);

   // Writes to read-only or unmapped numbers are dropped silently
   always_comb begin
      cfg_d   = cfg_q;
      drop_d  = drop_q;
      paus_d  = paus_q;
      resu_d  = resu_q;
      flood_d = flood_q;
      if (reg_wr) begin
         case (reg_addr)
            ADR_CFG:  cfg_d   = reg_wdata[CFG_W-1:0];
            ADR_DROP: drop_d  = reg_wdata[LVL_W-1:0];
            ADR_PAUS: paus_d  = reg_wdata[LVL_W-1:0];
            ADR_RESU: resu_d  = reg_wdata[LVL_W-1:0];
            ADR_FLOD: flood_d = reg_wdata[FLOOD_W-1:0];
            default:  cfg_d   = cfg_q;
         endcase
      end
   end

   // Drop counters
   always_comb begin
      for (int c = 0; c < NCNT; c++) begin
         cnt_d[c] = cnt_q[c];
         if (cnt_rd[c]) begin
            cnt_d[c] = cfg_q.cnt_test ? CNT_TEST : CNT_RST;
         end
         if (inc[c] && cnt_d[c] != CNT_MAX) begin
            cnt_d[c] = cnt_d[c] + 32'h1;
         end
      end
   end

   // Read mux; unmapped numbers and reserved bits read as zero
   always_comb begin
      rdata_d = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            ADR_CFG:  rdata_d = {25'h0, cfg_q};
            ADR_DROP: rdata_d = {16'h0, drop_q};
            ADR_PAUS: rdata_d = {16'h0, paus_q};
            ADR_RESU: rdata_d = {16'h0, resu_q};
            ADR_FLOD: rdata_d = {24'h0, flood_q};
            ADR_CNT0: rdata_d = cnt_q[0];
            ADR_CNT1: rdata_d = cnt_q[1];
            default:  rdata_d = 32'h0;
         endcase
      end
   end

   // Register bank
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q   <= CFG_RST;
         drop_q  <= {DROP_LOW_RST, DROP_HI_RST};
         paus_q  <= {PAUS_LOW_RST, PAUS_HI_RST};
         resu_q  <= {RESU_LOW_RST, RESU_HI_RST};
         flood_q <= FLOOD_RST;
         rdata_q <= 32'h0;
         for (int c = 0; c < NCNT; c++) begin
            cnt_q[c] <= CNT_RST;
         end
      end else begin
         cfg_q   <= cfg_d;
         drop_q  <= drop_d;
         paus_q  <= paus_d;
         resu_q  <= resu_d;
         flood_q <= flood_d;
         rdata_q <= rdata_d;
         for (int c = 0; c < NCNT; c++) begin
            cnt_q[c] <= cnt_d[c];
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // servicing order
   assign cfg_out     = cfg_q;
   assign reg_rdata   = rdata_q;
   assign adm_done    = done_q;
   assign adm_drop    = drp_q;
   assign active_cnt  = act_n;
   assign over_limit  = over_q;
   assign pause_send  = psend_q;
   assign resume_send = rsend_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_cnt0_plain_rd;
      cnt_rd[0] && !cfg_q.cnt_test && !inc[0];
   endsequence

   sequence s_cnt0_test_rd;
      cnt_rd[0] && cfg_q.cnt_test && !inc[0];
   endsequence

   a_cnt_test_load: assert property (
      s_cnt0_test_rd |=> cnt_q[0] == CNT_TEST)
      else $error("test read did not load pattern");

   a_cfg_write_path: assert property (
      reg_wr && reg_addr == ADR_CFG |=> cfg_out == $past(reg_wdata[6:0]))
      else $error("config write not seen at output");

   a_limit_set_sel: assert property (
      (act_n >= 2'h2 && buf_used[0] >= {2'h0, drop_q.low}) ||
      (act_n <  2'h2 && buf_used[0] >= {2'h0, drop_q.high}) |=> over_limit[0])
      else $error("port over limit not flagged");

   a_red_drop_now: assert property (
      adm_req.valid && adm_req.port != 2'h3 && adm_req.red && cfg_q.red_en
      |=> adm_done && adm_drop)
      else $error("red packet not dropped");

   a_pause_once: assert property (
      !paused_q[0] && buf_used[0] >= {2'h0, paus_lim}
      |=> pause_send[0] ##1 !pause_send[0])
      else $error("pause not sent once");

   a_resume_pulse: assert property (
      paused_q[0] && buf_used[0] <= {2'h0, resu_lim}
      |=> resume_send[0] && !paused_q[0])
      else $error("resume not sent");

   a_cnt_clear_rd: assert property (
      s_cnt0_plain_rd |=> cnt_q[0] == 32'h0 && reg_rdata == $past(cnt_q[0]))
      else $error("counter not cleared");

   a_rd_returns_cnt: assert property (
      cnt_rd[1] |=> reg_rdata == $past(cnt_q[1]))
      else $error("counter read data wrong");

   a_cnt_saturate: assert property (
      cnt_q[0] == CNT_MAX && !cnt_rd[0] |=> cnt_q[0] == CNT_MAX)
      else $error("counter wrapped");

   a_evt_after_clr: assert property (
      cnt_rd[0] && !cfg_q.cnt_test && inc[0] |=> cnt_q[0] == 32'h1)
      else $error("drop lost on clearing read");

   a_cnt_increment: assert property (
      inc[1] && !cnt_rd[1] && cnt_q[1] != CNT_MAX |=> cnt_q[1] == $past(cnt_q[1]) + 32'h1)
      else $error("drop not counted");

endmodule : sbml_limits
`default_nettype wire

// file: sbml_engine_model.sv
// Purpose: Switch engine stand-in feeding usage, drops and requests
// Assumes: The bench sets levels and one request per go cycle
// Notes:   Outputs are registered, so everything lands one cycle late
`timescale 1ns/1ps
`default_nettype none
module sbml_engine_model (
   // Clock
   input  wire logic                   clk,
   // Bench commands
   input  wire logic [2:0][9:0]        use_set,
   input  wire logic [9:0]             flood_set,
   input  wire logic [2:0]             yel_set,
   input  wire sbml_pkg::sbml_adm_type req_set,
   // Engine side of the block
   output logic      [2:0][9:0]        buf_used,
   output logic      [9:0]             flood_used,
   output logic      [2:0]             yellow_drop,
   output sbml_pkg::sbml_adm_type      adm_req
);
   import sbml_pkg::*;
   // Start from idle so no request appears before the bench asks
   initial begin
      adm_req = '0;
      yellow_drop = '0;
   end
   always @(posedge clk) begin
      buf_used <= use_set;
      flood_used <= flood_set;
      yellow_drop <= yel_set;
      adm_req <= req_set;
   end
endmodule : sbml_engine_model
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench of the buffer limits bank
// Assumes: Engine stand-in sits between bench and block
// Notes:   Model of registers and counters is kept in ints
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
   import sbml_pkg::*;
   logic                clk = 1'b0;
   logic                srst = 1'b1;
   logic [15:0]         reg_addr = '0;
   logic [31:0]         reg_wdata = '0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [31:0]         reg_rdata;
   logic [2:0][9:0]     use_set = '0;
   logic [9:0]          flood_set = '0;
   logic [2:0]          yel_set = '0;
   sbml_adm_type        req_set = '0;
   logic [2:0][9:0]     buf_used;
   logic [9:0]          flood_used;
   logic [2:0]          yellow_drop;
   sbml_adm_type        adm_req;
   logic                adm_done;
   logic                adm_drop;
   sbml_cfg_type        cfg_out;
   logic [1:0]          active_cnt;
   logic [2:0]          over_limit;
   logic [2:0]          pause_send;
   logic [2:0]          resume_send;
   int                  fail_count = 0;
   int                  n_checks = 0;
   int                  np = 0;
   int                  nr = 0;
   int                  u[3] = '{0, 0, 0};
   int                  fu = 0;
   int mreg[7] = '{0, 'h4964, 'h213c, 'h0307, 'h31, 0, 0};
   int msk[7] = '{'h7f, 'hffff, 'hffff, 'hffff, 'hff, 0, 0};
   logic [31:0]         seed = 32'hc9b400cc;
   logic [31:0]         v;

   sbml_engine_model u_eng (.clk, .use_set, .flood_set, .yel_set, .req_set,
      .buf_used, .flood_used, .yellow_drop, .adm_req);
   sbml_limits u_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .buf_used, .flood_used, .yellow_drop, .adm_req, .adm_done,
      .adm_drop, .cfg_out, .active_cnt, .over_limit, .pause_send,
      .resume_send);

   // 25 MHz clock
   always #20 clk = ~clk;
   // Pulses on port 0 are counted since one lasts a single cycle
   always @(posedge clk) begin
      np <= np + int'(pause_send[0] === 1'b1);
      nr <= nr + int'(resume_send[0] === 1'b1);
   end

   function automatic logic [31:0] nx();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : nx
   function automatic int na();
      na = 0;
      foreach (u[k]) na += int'(u[k] >= 36);
   endfunction : na
   // Low set with two or more active ports, else high set
   function automatic int lim(input int r);
      return na() >= 2 ? int'(mreg[r][15:8]) : int'(mreg[r][7:0]);
   endfunction : lim

   task automatic wr(input int i, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= 16'h1c00 + 16'(i);
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (i < 5) mreg[i] = d & msk[i];
   endtask : wr
   task automatic rc(input int i);
      logic [31:0] e;
      e = (i < 7) ? mreg[i] : 0;
      @(posedge clk);
      reg_addr <= 16'h1c00 + 16'(i);
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
      if (i == 5 || i == 6) mreg[i] = mreg[0][6] ? 'h07fffffc : 0;
   endtask : rc
   task automatic lv(input int a, input int b, input int c, input int f);
      logic [2:0] o;
      u = '{a, b, c};
      fu = f;
      @(posedge clk);
      use_set <= {10'(c), 10'(b), 10'(a)};
      flood_set <= 10'(f);
      repeat (3) @(posedge clk);
      #1;
      foreach (u[k]) o[k] = u[k] >= lim(1);
      `CHK(active_cnt, 2'(na()))
      `CHK(over_limit, o)
   endtask : lv
   task automatic adm(input int p, input bit red, input bit fl);
      bit e;
      e = p < 3 && ((red && mreg[0][0]) || u[p] >= lim(1) || (fl && fu >= mreg[4]));
      @(posedge clk);
      req_set <= '{1'b1, 2'(p), red, fl};
      @(posedge clk);
      req_set <= '0;
      @(posedge clk);
      #1;
      `CHK(adm_done, p < 3)
      `CHK(adm_drop, e)
      if (e && p < 2) mreg[5 + p]++;
   endtask : adm
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // Hang guard, well beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   // --------------------------------------------
   // Main sequence
   // --------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) rc(i);
      $display("reset values done");
      lv(59, 0, 0, 0);
      lv(60, 0, 0, 0);
      lv(8, 0, 0, 0);
      lv(7, 0, 0, 0);
      `CHK(np, 1)
      `CHK(nr, 1)
      lv(33, 36, 36, 0);
      lv(4, 36, 36, 0);
      lv(3, 35, 36, 0);
      `CHK(np, 2)
      `CHK(nr, 2)
      $display("flow control done");
      for (int i = 0; i < 8; i++) wr(i, nx());
      for (int i = 0; i < 8; i++) rc(i);
      `CHK(cfg_out, 7'(mreg[0]))
      $display("register access done");
      // Random usage and requests against the drop model
      for (int k = 0; k < 16; k++) begin
         v = nx();
         lv(int'(v[6:0]), int'(v[13:7]), int'(v[20:14]), int'(v[26:21]));
         adm(v[28:27] == 2'd3 ? 0 : int'(v[28:27]), v[29], v[30]);
      end
      wr(0, 32'h01);
      wr(1, 32'hffff);
      lv(0, 0, 0, 0);
      adm(1, 1'b1, 1'b0);
      adm(0, 1'b0, 1'b0);
      adm(3, 1'b1, 1'b0);
      @(posedge clk);
      yel_set <= 3'b101;
      @(posedge clk);
      yel_set <= 3'b000;
      mreg[5]++;
      repeat (2) @(posedge clk);
      for (int i = 5; i < 7; i++) rc(i);
      for (int i = 5; i < 7; i++) rc(i);
      $display("drop counting done");
      wr(0, 32'h41);
      adm(0, 1'b1, 1'b0);
      rc(5);
      rc(5);
      wr(0, 32'h00);
      rc(5);
      rc(5);
      // A yellow drop meets a clearing read in the same cycle
      @(posedge clk);
      reg_addr <= ADR_CNT0;
      yel_set <= 3'b001;
      @(posedge clk);
      yel_set <= 3'b000;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, 32'(mreg[5]))
      mreg[5] = 1;
      rc(5);
      $display("counter test done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
